// File: design/ilpd_pkg.sv
// Package of constants and types for the instruction length predecoder.
package ilpd_pkg;

	// ****************************************
	// Line and instruction geometry
	// ****************************************
	localparam int LINE_BYTES = 32;
	localparam int POS_W = 5;
	localparam int LEN_W = 3;
	localparam logic [3:0] MAX_LEN = 4'h7;
	localparam int MAX_EXAMINE = 3;

	// ****************************************
	// Opcode and addressing constants
	// ****************************************
	localparam logic [7:0] ESC_BYTE = 8'h0f;
	localparam logic [7:0] OP_STATE_EXIT = 8'h77;
	localparam logic [7:0] OP_FAST_STATE_EXIT = 8'h0e;
	localparam logic [7:0] OP_PREFETCH = 8'h0d;
	localparam logic [7:0] OP_PFLOAT = 8'h0f;
	localparam logic [1:0] MOD_NODISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP32 = 2'h2;
	localparam logic [2:0] RM_SIB = 3'h4;
	localparam logic [2:0] RM_DISP32 = 3'h5;
	localparam logic [2:0] RM_SRCIDX = 3'h6;
	localparam logic [2:0] SIB_NOBASE = 3'h5;

	// ****************************************
	// Decode cost in half cycles
	// ****************************************
	localparam logic [1:0] COST_SHORT_HALF = 2'h1;
	localparam logic [2:0] COST_LONG_HALF = 3'h2;
	localparam logic [2:0] COST_VECTOR_HALF = 3'h4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ILPD_PATH_SHORT = 2'h0,
		ILPD_PATH_LONG = 2'h1,
		ILPD_PATH_VECTOR = 2'h2
	} ilpd_path_e;

	typedef struct packed {
		logic valid;
		logic [LEN_W-1:0] len;
	} ilpd_mark_s;

	typedef enum logic [2:0] {
		ILPD_ST_IDLE = 3'h1,
		ILPD_ST_SCAN = 3'h2,
		ILPD_ST_DONE = 3'h4
	} ilpd_state_e;

endpackage

// File: design/ilpd_scan_if.sv
// Interface carrying one scan request and its length answer.
`timescale 1ns/1ns
interface ilpd_scan_if;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [1:0] avail;
	logic ok;
	logic [2:0] len;
	logic pfloat;
	logic is_mm;
	modport req (output b0, b1, b2, avail, input ok, len, pfloat, is_mm);
	modport calc (input b0, b1, b2, avail, output ok, len, pfloat, is_mm);
endinterface // ilpd_scan_if

// File: design/ilpd_len_calc.sv
// Combinational length calculation from the leading bytes of one instruction.
`timescale 1ns/1ns
module ilpd_len_calc (
	ilpd_scan_if.calc s // Scan request and answer.
);
	logic has_esc;
	logic [7:0] op;
	logic [7:0] mrm;
	logic sib_nodisp;
	logic [3:0] total;

	always_comb begin
		// RQ4 escape opcode modrm
		has_esc = (s.b0 == ilpd_pkg::ESC_BYTE);
		op = has_esc ? s.b1 : s.b0;
		mrm = has_esc ? s.b2 : s.b1;
		sib_nodisp = (mrm[7:6] == ilpd_pkg::MOD_NODISP) && (mrm[2:0] == ilpd_pkg::RM_SIB);
		// RQ15 multimedia bytes together
		s.is_mm = has_esc && (op[7:4] >= 4'h6 || op == ilpd_pkg::OP_PFLOAT);
		s.pfloat = has_esc && (op == ilpd_pkg::OP_PFLOAT);
		total = has_esc ? 4'h3 : 4'h2;
		if (s.pfloat) begin
			total = total + 4'h1;
		end
		// RQ7 disp forms remain
		unique case (mrm[7:6])
			ilpd_pkg::MOD_NODISP: begin
				if (mrm[2:0] == ilpd_pkg::RM_DISP32) begin
					total = total + 4'h4;
				end else if (mrm[2:0] == ilpd_pkg::RM_SIB) begin
					// RQ5 sib examined
					total = total + ((s.b2[2:0] == ilpd_pkg::SIB_NOBASE) ? 4'h5 : 4'h1);
				end
			end
			ilpd_pkg::MOD_DISP8: total = total + ((mrm[2:0] == ilpd_pkg::RM_SIB) ? 4'h2 : 4'h1);
			ilpd_pkg::MOD_DISP32: total = total + ((mrm[2:0] == ilpd_pkg::RM_SIB) ? 4'h5 : 4'h4);
			default: total = total;
		endcase
		s.ok = 1'b1;
		// RQ1 exits excluded
		if (!s.is_mm || (has_esc && (op == ilpd_pkg::OP_STATE_EXIT ||
				op == ilpd_pkg::OP_FAST_STATE_EXIT || op == ilpd_pkg::OP_PREFETCH))) begin
			s.ok = 1'b0;
		end
		// RQ6 three byte limit
		if (has_esc && sib_nodisp) begin
			s.ok = 1'b0;
		end
		// RQ8 source index
		if (mrm[7:6] == ilpd_pkg::MOD_NODISP && mrm[2:0] == ilpd_pkg::RM_SRCIDX) begin
			s.ok = 1'b0;
		end
		// RQ9 line end
		if ({1'b0, s.avail} < (has_esc ? 3'h3 : 3'h2)) begin
			s.ok = 1'b0;
		end
		// RQ2 RQ13 seven bytes
		if (total > ilpd_pkg::MAX_LEN) begin
			s.ok = 1'b0;
		end
		s.len = total[2:0];
	end
endmodule // ilpd_len_calc

// File: design/ilpd_top.sv
// Top of the instruction length predecoder with its predecode cache.
`timescale 1ns/1ns
// Functional notes
// RQ1 - Mark packed multimedia except exits and prefetch.
// RQ2 - Predecode only up to seven bytes.
// RQ3 - Length from first three bytes only.
// RQ4 - Examine escape, opcode and modR/M bytes.
// RQ5 - Sib without displacement also examines sib.
// RQ6 - Escape plus sib-no-displacement stays unmarked.
// RQ7 - Base and disp32 forms stay predecodable.
// RQ8 - Source-index no-displacement form stays unmarked.
// RQ9 - Never scan past line end.
// RQ10 - Predecode during fill, store in cache.
// RQ11 - Stored marker encodes instruction length.
// RQ12 - Unmarked integer vector, float long decode.
// RQ13 - Float with disp32 reaches eight, unmarked.
// RQ14 - Cost half, one, two cycles per path.
// RQ15 - Multimedia examines escape, opcode, modR/M together.
// RQ16 - Each byte marker valid or invalid.
module ilpd_top (
	input wire logic I_CLK, // Core clock.
	input wire logic I_RST_N, // Synchronous reset, active low.
	input wire logic I_FILL_VALID, // Fill line valid pulse.
	input wire logic [255:0] I_FILL_DATA, // Fill line bytes, byte 0 low.
	input wire logic [2:0] I_FILL_LINE, // Fill line index.
	input wire logic [2:0] I_RD_LINE, // Decoder lookup line.
	input wire logic [4:0] I_RD_POS, // Decoder lookup byte position.
	input wire logic I_RD_IS_MM_INT, // Byte starts a packed integer instruction.
	output logic O_FILL_BUSY, // Predecoder scanning a line or in its done cycle.
	output logic O_FILL_DONE, // Line markers written pulse.
	output logic O_RD_VALID, // Marker at lookup is valid.
	output logic [2:0] O_RD_LEN, // Length from the marker.
	output logic [1:0] O_RD_PATH, // Decode path chosen.
	output logic [2:0] O_RD_COST_HALF // Decode cost in half cycles.
);
	// ****************************************
	// Scan state
	// ****************************************
	ilpd_pkg::ilpd_state_e state, next_state;
	logic [255:0] line, next_line;
	logic [2:0] line_idx, next_line_idx;
	logic [4:0] pos, next_pos;
	ilpd_pkg::ilpd_mark_s marks [8][32];
	logic wr_en;
	logic [4:0] wr_pos;
	ilpd_pkg::ilpd_mark_s wr_mark;
	logic [5:0] step;
	ilpd_scan_if sif ();

	ilpd_len_calc u_calc (
		.s(sif)
	);

	function automatic logic [7:0] byte_at(input logic [255:0] d, input logic [5:0] p);
		byte_at = (p < 6'd32) ? d[p[4:0]*8 +: 8] : 8'h00;
	endfunction

	// RQ3 three bytes examined
	always_comb begin
		sif.b0 = byte_at(line, {1'b0, pos});
		sif.b1 = byte_at(line, {1'b0, pos} + 6'd1);
		sif.b2 = byte_at(line, {1'b0, pos} + 6'd2);
		// RQ9 bytes left
		sif.avail = (pos >= 5'd30) ? 2'(6'd32 - {1'b0, pos}) : 2'h3;
	end

	always_comb begin
		next_state = state;
		next_line = line;
		next_line_idx = line_idx;
		next_pos = pos;
		wr_en = 1'b0;
		wr_pos = pos;
		wr_mark = '0;
		step = 6'd1;
		unique case (state)
			ilpd_pkg::ILPD_ST_IDLE: begin
				// RQ10 scan on fill
				if (I_FILL_VALID) begin
					next_line = I_FILL_DATA;
					next_line_idx = I_FILL_LINE;
					next_pos = 5'd0;
					next_state = ilpd_pkg::ILPD_ST_SCAN;
				end
			end
			ilpd_pkg::ILPD_ST_SCAN: begin
				// RQ16 valid or invalid
				wr_en = 1'b1;
				wr_mark.valid = sif.ok;
				// RQ11 length stored
				wr_mark.len = sif.len;
				step = sif.ok ? {3'h0, sif.len} : 6'd1;
				if ({1'b0, pos} + step >= 6'd32) begin
					next_state = ilpd_pkg::ILPD_ST_DONE;
				end else begin
					next_pos = 5'({1'b0, pos} + step);
				end
			end
			ilpd_pkg::ILPD_ST_DONE: begin
				next_state = ilpd_pkg::ILPD_ST_IDLE;
			end
			default: next_state = ilpd_pkg::ILPD_ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			state <= ilpd_pkg::ILPD_ST_IDLE;
			line <= '0;
			line_idx <= 3'h0;
			pos <= 5'h0;
		end else begin
			state <= next_state;
			line <= next_line;
			line_idx <= next_line_idx;
			pos <= next_pos;
		end
	end

	// ****************************************
	// Predecode cache
	// ****************************************
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			for (int l = 0; l < 8; l++) begin
				for (int b = 0; b < 32; b++) begin
					marks[l][b] <= '0;
				end
			end
		end else if (state == ilpd_pkg::ILPD_ST_IDLE && I_FILL_VALID) begin
			for (int b = 0; b < 32; b++) begin
				marks[I_FILL_LINE][b] <= '0;
			end
		end else if (wr_en) begin
			marks[line_idx][wr_pos] <= wr_mark;
		end
	end

	// ****************************************
	// Decoder lookup
	// ****************************************
	logic rd_valid, next_rd_valid;
	logic [2:0] rd_len, next_rd_len;
	logic [1:0] rd_path, next_rd_path;
	logic [2:0] rd_cost, next_rd_cost;

	always_comb begin
		next_rd_valid = marks[I_RD_LINE][I_RD_POS].valid;
		next_rd_len = marks[I_RD_LINE][I_RD_POS].len;
		// RQ12 fallback path
		if (next_rd_valid) begin
			next_rd_path = ilpd_pkg::ILPD_PATH_SHORT;
		end else if (I_RD_IS_MM_INT) begin
			next_rd_path = ilpd_pkg::ILPD_PATH_VECTOR;
		end else begin
			next_rd_path = ilpd_pkg::ILPD_PATH_LONG;
		end
		// RQ14 decode cost
		unique case (next_rd_path)
			ilpd_pkg::ILPD_PATH_SHORT: next_rd_cost = {1'b0, ilpd_pkg::COST_SHORT_HALF};
			ilpd_pkg::ILPD_PATH_VECTOR: next_rd_cost = ilpd_pkg::COST_VECTOR_HALF;
			default: next_rd_cost = ilpd_pkg::COST_LONG_HALF;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			rd_valid <= 1'b0;
			rd_len <= 3'h0;
			rd_path <= ilpd_pkg::ILPD_PATH_LONG;
			rd_cost <= ilpd_pkg::COST_LONG_HALF;
		end else begin
			rd_valid <= next_rd_valid;
			rd_len <= next_rd_len;
			rd_path <= next_rd_path;
			rd_cost <= next_rd_cost;
		end
	end

	assign O_FILL_BUSY = (state != ilpd_pkg::ILPD_ST_IDLE);
	assign O_FILL_DONE = (state == ilpd_pkg::ILPD_ST_DONE);
	assign O_RD_VALID = rd_valid;
	assign O_RD_LEN = rd_len;
	assign O_RD_PATH = rd_path;
	assign O_RD_COST_HALF = rd_cost;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	a_len_max_seven: assert property (wr_en && wr_mark.valid |-> wr_mark.len != 3'h0) // RQ2
		else $error("Valid marker with zero length.");
	a_esc_sib_reject: assert property (wr_en && sif.b0 == ilpd_pkg::ESC_BYTE && // RQ6
		sif.b2[7:6] == ilpd_pkg::MOD_NODISP && sif.b2[2:0] == ilpd_pkg::RM_SIB
		|-> !wr_mark.valid) else $error("Escaped sib form was marked.");
	a_srcidx_reject: assert property (wr_en && sif.b0 == ilpd_pkg::ESC_BYTE && // RQ8
		sif.b2[7:6] == ilpd_pkg::MOD_NODISP && sif.b2[2:0] == ilpd_pkg::RM_SRCIDX
		|-> !wr_mark.valid) else $error("Source index form was marked.");
	a_line_end: assert property (wr_en && pos == 5'd31 |-> !wr_mark.valid) // RQ9
		else $error("Last byte was marked.");
	a_fill_done: assert property (state == ilpd_pkg::ILPD_ST_IDLE && I_FILL_VALID // RQ10
		|-> ##[2:33] O_FILL_DONE)
		else $error("Fill scan did not finish.");
	a_exit_reject: assert property (wr_en && sif.b0 == ilpd_pkg::ESC_BYTE && // RQ1
		sif.b1 == ilpd_pkg::OP_STATE_EXIT |-> !wr_mark.valid)
		else $error("State exit instruction was marked.");
	a_path_cost: assert property (O_RD_PATH == ilpd_pkg::ILPD_PATH_SHORT |-> // RQ14
		O_RD_COST_HALF == {1'b0, ilpd_pkg::COST_SHORT_HALF} && O_RD_VALID)
		else $error("Short path cost wrong.");
	a_fallback: assert property ($past(I_RST_N) && !O_RD_VALID && $past(I_RD_IS_MM_INT) // RQ12
		|-> O_RD_PATH == ilpd_pkg::ILPD_PATH_VECTOR)
		else $error("Integer fallback not vector.");

	c_fill: cover property (O_FILL_DONE);
	c_short: cover property (O_RD_VALID);
	c_vector: cover property (O_RD_PATH == 2'h2);
	c_long: cover property (O_RD_PATH == ilpd_pkg::ILPD_PATH_LONG);
	c_reject: cover property (wr_en && !wr_mark.valid);
endmodule // ilpd_top

// File: dv/ilpd_fill_model.sv
// Model of the cache fill path that hands whole lines to the predecoder.
`timescale 1ns/1ns
module ilpd_fill_model (
	input wire logic i_clk, // Core clock.
	input wire logic i_busy, // Predecoder scanning or in its done cycle.
	input wire logic i_done, // Line markers written.
	output logic o_valid, // Fill pulse.
	output logic [255:0] o_data, // Line bytes.
	output logic [2:0] o_line // Line index.
);
	initial begin
		o_valid = 1'b0;
		o_data = '0;
		o_line = 3'h0;
	end

	// ****************************************
	// Line fill
	// ****************************************
	// A refused second request may follow the taken one; released data is inverted.
	task automatic fill(input logic [2:0] line, input logic [255:0] data, input int gap,
		input bit intrude, output bit ok);
		bit seen;
		seen = 1'b0;
		ok = 1'b0;
		repeat (gap + 1) @(posedge i_clk);
		#1;
		o_valid = 1'b1;
		o_data = data;
		o_line = line;
		@(posedge i_clk);
		#1;
		seen = (i_busy === 1'b1);
		if (intrude) begin
			o_line = line + 3'h1;
			@(posedge i_clk);
			#1;
		end
		o_valid = 1'b0;
		o_data = ~data;
		for (int n = 0; n < 40 && !ok; n++) begin
			if (i_done === 1'b1) ok = seen;
			else begin
				@(posedge i_clk);
				#1;
			end
		end
	endtask
endmodule // ilpd_fill_model

// File: dv/ilpd_top_bench.sv
// Self-checking bench for the instruction length predecoder.
`timescale 1ns/1ns
module ilpd_top_bench;
	logic I_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic fv;
	logic [255:0] fd;
	logic [2:0] fl;
	logic [2:0] rl = 3'h0;
	logic [4:0] rp = 5'h00;
	logic mi = 1'b0;
	logic busy, done, rv;
	logic [2:0] rlen, rcost;
	logic [1:0] rpath;
	logic [255:0] d1, d2;
	int mismatches = 0;
	int num_checks = 0;

	always #20 I_CLK = ~I_CLK;

	ilpd_top u_ilpd_top (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_FILL_VALID(fv),
		.I_FILL_DATA(fd), .I_FILL_LINE(fl), .I_RD_LINE(rl), .I_RD_POS(rp),
		.I_RD_IS_MM_INT(mi), .O_FILL_BUSY(busy), .O_FILL_DONE(done), .O_RD_VALID(rv),
		.O_RD_LEN(rlen), .O_RD_PATH(rpath), .O_RD_COST_HALF(rcost));
	ilpd_fill_model u_ilpd_fill_model (.i_clk(I_CLK), .i_busy(busy), .i_done(done),
		.o_valid(fv), .o_data(fd), .o_line(fl));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic fail(input string msg);
		mismatches++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask

	task automatic fill(input logic [2:0] line, input logic [255:0] d, input int gap,
		input bit intr);
		bit ok;
		num_checks++;
		u_ilpd_fill_model.fill(line, d, gap, intr, ok);
		if (!ok) begin
			fail("fill not completed");
			conclude();
		end
	endtask

	// Looks up one marker and judges validity, length, path and cost.
	task automatic look(input logic [2:0] line, input logic [4:0] pos, input logic m,
		input logic ev, input logic [2:0] el);
		logic [1:0] ep;
		logic [2:0] ec;
		ep = ev ? ilpd_pkg::ILPD_PATH_SHORT : m ? ilpd_pkg::ILPD_PATH_VECTOR
			: ilpd_pkg::ILPD_PATH_LONG;
		ec = ev ? {1'b0, ilpd_pkg::COST_SHORT_HALF} : m ? ilpd_pkg::COST_VECTOR_HALF
			: ilpd_pkg::COST_LONG_HALF;
		@(posedge I_CLK);
		#1;
		rl = line;
		rp = pos;
		mi = m;
		@(posedge I_CLK);
		#1;
		num_checks++;
		if (rv !== ev || (ev && rlen !== el) || rpath !== ep || rcost !== ec)
			fail($sformatf("marker line %0d pos %0d", line, pos));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_after_reset();
		num_checks++;
		if (busy !== 1'b0 || done !== 1'b0) fail("busy or done after reset");
		look(3'h1, 5'h00, 1'b1, 1'b0, 3'h0);
	endtask

	task automatic t_forms();
		d1 = {32{8'h90}};
		d1[0+:24] = 24'hc1fc0f;
		d1[24+:32] = 32'h04466f0f;
		d1[56+:56] = 56'h44332211806f0f;
		d1[112+:56] = 56'h44332211056f0f;
		d1[168+:32] = 32'h9ec10f0f;
		d1[200+:24] = 24'h066f0f;
		d1[224+:32] = 32'h24046f0f;
		fill(3'h1, d1, 0, 1'b0);
		look(3'h1, 5'h00, 1'b1, 1'b1, 3'h3);
		look(3'h1, 5'h03, 1'b1, 1'b1, 3'h4);
		look(3'h1, 5'h07, 1'b1, 1'b1, 3'h7);
		look(3'h1, 5'h0e, 1'b1, 1'b1, 3'h7);
		look(3'h1, 5'h15, 1'b0, 1'b1, 3'h4);
		look(3'h1, 5'h19, 1'b1, 1'b0, 3'h0);
		look(3'h1, 5'h1c, 1'b1, 1'b0, 3'h0);
		look(3'h1, 5'h01, 1'b0, 1'b0, 3'h0);
	endtask

	task automatic t_exits_edges();
		d2 = {32{8'h90}};
		d2[0+:16] = 16'h770f;
		d2[16+:16] = 16'h0e0f;
		d2[32+:24] = 24'h000d0f;
		d2[56+:64] = 64'h9e44332211800f0f;
		d2[128+:40] = 40'h1024446f0f;
		d2[168+:64] = 64'h4433221124846f0f;
		d2[240+:16] = 16'h0f0f;
		fill(3'h2, d2, 3, 1'b0);
		look(3'h2, 5'h00, 1'b0, 1'b0, 3'h0);
		look(3'h2, 5'h02, 1'b0, 1'b0, 3'h0);
		look(3'h2, 5'h04, 1'b0, 1'b0, 3'h0);
		look(3'h2, 5'h07, 1'b0, 1'b0, 3'h0);
		look(3'h2, 5'h10, 1'b1, 1'b1, 3'h5);
		look(3'h2, 5'h15, 1'b1, 1'b0, 3'h0);
		look(3'h2, 5'h1e, 1'b1, 1'b0, 3'h0);
		look(3'h2, 5'h1f, 1'b1, 1'b0, 3'h0);
		look(3'h1, 5'h00, 1'b1, 1'b1, 3'h3);
	endtask

	task automatic t_refused_and_reset();
		fill(3'h3, d1, 0, 1'b1);
		look(3'h3, 5'h03, 1'b1, 1'b1, 3'h4);
		look(3'h4, 5'h03, 1'b1, 1'b0, 3'h0);
		@(posedge I_CLK);
		#1;
		I_RST_N = 1'b0;
		@(posedge I_CLK);
		#1;
		I_RST_N = 1'b1;
		look(3'h3, 5'h03, 1'b1, 1'b0, 3'h0);
	endtask

	initial begin
		repeat (5) @(posedge I_CLK);
		#1;
		I_RST_N = 1'b1;
		t_after_reset();
		t_forms();
		t_exits_edges();
		t_refused_and_reset();
		conclude();
	end
endmodule // ilpd_top_bench
